//--- rtl/mrie_link_force.sv
// registered link data stage that forces all lines high on demand
`timescale 1ns/1ps
module mrie_link_force #(
  parameter int WIDTH = 32
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic force_high, // drive every line to one
  input wire logic [WIDTH-1:0] data_in, // data from the transmitter
  output logic [WIDTH-1:0] data_out // registered pin data
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= '1;
    end else if (force_high) begin
      data_out <= '1;
    end else begin
      data_out <= data_in;
    end
  end

endmodule

//--- rtl/mrie_master_ctrl.sv
// master control: software reset, interrupt enable mask, status and host interrupt
`timescale 1ns/1ps
module mrie_master_ctrl (
  input wire logic clk, // 40 MHz host clock
  input wire logic rst_n, // hardware reset, active low
  input wire mrie_pkg::mrie_host_req_t host_req, // host target cycle, one-cycle request
  output logic host_ack, // one-cycle answer to every request
  output logic [31:0] host_rdata, // registered read data
  input wire mrie_pkg::mrie_irq_bits_t event_in, // one-cycle event pulses from the cores
  input wire logic [31:0] tx_link_data_in, // transmit data from the core
  output logic [31:0] tx_link_data_out, // transmit link data pins
  output logic host_interrupt_out_n, // host interrupt, active low
  output logic core_reset_n, // reset for every core function, active low
  output logic config_reset_n, // reset for configuration registers, active low
  output logic low_power_standby, // standby request to clocks and cores
  output logic pci_pin_drive_en // host interface pin drivers enabled
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic soft_reset;
  mrie_pkg::mrie_irq_bits_t irq_enable;
  mrie_pkg::mrie_irq_bits_t irq_status;
  mrie_pkg::mrie_irq_bits_t irq_gated;
  logic take;
  logic wr_soft;
  logic wr_enable;
  logic rd_status;
  logic next_irq_n;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // host decode

  // a cycle with every lane negated is answered but touches nothing
  assign take = host_req.access && (host_req.be_n != mrie_pkg::ALL_LANES_NEGATED);
  // lanes are not looked at past this point: whole-word writes only
  assign wr_soft = take && host_req.write && (host_req.addr == mrie_pkg::OFS_SOFT_RESET);
  assign wr_enable = take && host_req.write && (host_req.addr == mrie_pkg::OFS_IRQ_ENABLE);
  assign rd_status = take && !host_req.write && (host_req.addr == mrie_pkg::OFS_IRQ_STATUS);

  always_comb begin
    next_rdata = mrie_pkg::UNMAPPED_READ;
    if (take && !host_req.write) begin
      case (host_req.addr)
        mrie_pkg::OFS_SOFT_RESET: begin
          next_rdata[mrie_pkg::SOFT_RESET_BIT] = soft_reset;
        end
        mrie_pkg::OFS_IRQ_ENABLE: begin
          next_rdata[15:0] = irq_enable;
        end
        mrie_pkg::OFS_IRQ_STATUS: begin
          next_rdata[15:0] = irq_status;
        end
        default: begin
          next_rdata = mrie_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= mrie_pkg::UNMAPPED_READ;
    end else if (host_req.access) begin
      host_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_ack <= 1'b0;
    end else begin
      host_ack <= host_req.access;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software reset

  // only hardware reset or a host write with SOFT_RESET_BIT clear releases it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset <= mrie_pkg::SOFT_RESET_RST;
    end else if (wr_soft) begin
      soft_reset <= host_req.wdata[mrie_pkg::SOFT_RESET_BIT];
    end
  end

  assign core_reset_n = rst_n && !soft_reset;
  assign low_power_standby = soft_reset;
  // configuration space only follows the hardware reset
  assign config_reset_n = rst_n;

  // drivers float in hardware reset, stay on through software reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pci_pin_drive_en <= 1'b0;
    end else begin
      pci_pin_drive_en <= 1'b1;
    end
  end

  mrie_link_force #(
    .WIDTH(mrie_pkg::LINK_W)
  ) u_link_force (
    .clk(clk),
    .rst_n(rst_n),
    .force_high(soft_reset),
    .data_in(tx_link_data_in),
    .data_out(tx_link_data_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt enable and status

  // held at default while in software reset; writes then are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= mrie_pkg::IRQ_ENABLE_RST;
    end else if (soft_reset) begin
      irq_enable <= mrie_pkg::IRQ_ENABLE_RST;
    end else if (wr_enable) begin
      irq_enable <= host_req.wdata[15:0];
    end
  end

  // status sets regardless of the mask, so masked events can be polled
  mrie_sticky_flags #(
    .WIDTH(mrie_pkg::IRQ_W)
  ) u_status (
    .clk(clk),
    .rst_n(rst_n),
    .hold_clear(soft_reset),
    .read_clear(rd_status),
    .set_in(event_in),
    .flags(irq_status)
  );

  assign irq_gated.sys_error = irq_status.sys_error & irq_enable.sys_error;
  assign irq_gated.parity_error = irq_status.parity_error & irq_enable.parity_error;
  assign irq_gated.rx_check_error = irq_status.rx_check_error & irq_enable.rx_check_error;
  assign irq_gated.rx_abort = irq_status.rx_abort & irq_enable.rx_abort;
  assign irq_gated.rx_format_error = irq_status.rx_format_error & irq_enable.rx_format_error;
  assign irq_gated.rx_overrun = irq_status.rx_overrun & irq_enable.rx_overrun;
  assign irq_gated.rx_small_free_read = irq_status.rx_small_free_read & irq_enable.rx_small_free_read;
  assign irq_gated.rx_large_free_read = irq_status.rx_large_free_read & irq_enable.rx_large_free_read;
  assign irq_gated.rx_ready_write = irq_status.rx_ready_write & irq_enable.rx_ready_write;
  assign irq_gated.rx_free_empty = irq_status.rx_free_empty & irq_enable.rx_free_empty;
  assign irq_gated.rx_ready_full = irq_status.rx_ready_full & irq_enable.rx_ready_full;
  assign irq_gated.tx_free_write = irq_status.tx_free_write & irq_enable.tx_free_write;
  assign irq_gated.tx_ready_read = irq_status.tx_ready_read & irq_enable.tx_ready_read;
  assign irq_gated.tx_free_full = irq_status.tx_free_full & irq_enable.tx_free_full;
  assign irq_gated.tx_complete = irq_status.tx_complete & irq_enable.tx_complete;
  assign irq_gated.tx_underflow = irq_status.tx_underflow & irq_enable.tx_underflow;

  assign next_irq_n = !(|irq_gated);

  // registered so the pin never glitches during a read clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_interrupt_out_n <= 1'b1;
    end else begin
      host_interrupt_out_n <= next_irq_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_whole_word_write: assert property (
    (wr_enable && !soft_reset) |=> (irq_enable == $past(host_req.wdata[15:0])))
    else $error("enable write did not replace all bits");

  chk_lanes_negated: assert property (
    (host_req.access && host_req.be_n == 4'hF && !soft_reset && event_in == 16'h0000)
      |=> ($stable(irq_enable) && $stable(soft_reset) && $stable(irq_status)))
    else $error("access made with all lanes negated");

  chk_core_held: assert property (
    soft_reset |-> (!core_reset_n && low_power_standby))
    else $error("core not held in software reset");

  chk_soft_sticky: assert property (
    (soft_reset && !wr_soft) |=> soft_reset)
    else $error("software reset cleared itself");

  chk_pins_driven: assert property (
    soft_reset |-> pci_pin_drive_en)
    else $error("host pins released during software reset");

  chk_link_forced: assert property (
    soft_reset |=> (tx_link_data_out == 32'hFFFF_FFFF))
    else $error("link data not forced high");

  chk_regs_default: assert property (
    soft_reset |=> (irq_enable == 16'h0000 && irq_status == 16'h0000))
    else $error("registers not at default in software reset");

  // other enabled sources may hold the pin low, so only a quiet start counts
  chk_masked_poll: assert property (
    (!soft_reset && event_in.sys_error && !irq_enable.sys_error && !(|irq_gated))
      |=> (irq_status.sys_error && host_interrupt_out_n))
    else $error("masked event lost or interrupt not masked");

  chk_read_clear: assert property (
    (rd_status && !soft_reset && event_in == 16'h0000) |=> (irq_status == 16'h0000))
    else $error("status read did not clear");

  chk_set_wins: assert property (
    (rd_status && !soft_reset && event_in.rx_abort) |=> irq_status.rx_abort)
    else $error("event lost in clear cycle");

  chk_irq_follows: assert property (
    ##1 (host_interrupt_out_n == !$past(|(irq_status & irq_enable))))
    else $error("interrupt pin does not follow enabled status");

  chk_irq_latency: assert property (
    (!soft_reset && irq_enable.sys_error && event_in.sys_error && !rd_status && !wr_enable)
      ##1 !soft_reset |=> !host_interrupt_out_n)
    else $error("enabled event did not raise interrupt in two cycles");

  chk_sys_gate: assert property (
    (irq_status.sys_error && irq_enable.sys_error) |=> !host_interrupt_out_n)
    else $error("enabled system error did not raise interrupt");

  chk_parity_gate: assert property (
    (irq_status.parity_error && irq_enable.parity_error) |=> !host_interrupt_out_n)
    else $error("enabled parity error did not raise interrupt");

  chk_check_gate: assert property (
    (irq_status.rx_check_error && irq_enable.rx_check_error) |=> !host_interrupt_out_n)
    else $error("enabled check error did not raise interrupt");

  chk_abort_gate: assert property (
    (irq_status.rx_abort && irq_enable.rx_abort) |=> !host_interrupt_out_n)
    else $error("enabled abort did not raise interrupt");

  chk_format_gate: assert property (
    (irq_status.rx_format_error && irq_enable.rx_format_error) |=> !host_interrupt_out_n)
    else $error("enabled format error did not raise interrupt");

  chk_overrun_gate: assert property (
    (irq_status.rx_overrun && irq_enable.rx_overrun) |=> !host_interrupt_out_n)
    else $error("enabled overrun did not raise interrupt");

  chk_small_free_gate: assert property (
    (irq_status.rx_small_free_read && irq_enable.rx_small_free_read) |=> !host_interrupt_out_n)
    else $error("enabled small free read did not raise interrupt");

  chk_large_free_gate: assert property (
    (irq_status.rx_large_free_read && irq_enable.rx_large_free_read) |=> !host_interrupt_out_n)
    else $error("enabled large free read did not raise interrupt");

  chk_ready_write_gate: assert property (
    (irq_status.rx_ready_write && irq_enable.rx_ready_write) |=> !host_interrupt_out_n)
    else $error("enabled ready write did not raise interrupt");

  chk_free_empty_gate: assert property (
    (irq_status.rx_free_empty && irq_enable.rx_free_empty) |=> !host_interrupt_out_n)
    else $error("enabled free empty did not raise interrupt");

  chk_ready_full_gate: assert property (
    (irq_status.rx_ready_full && irq_enable.rx_ready_full) |=> !host_interrupt_out_n)
    else $error("enabled ready full did not raise interrupt");

  chk_underflow_gate: assert property (
    (irq_status.tx_underflow && irq_enable.tx_underflow) |=> !host_interrupt_out_n)
    else $error("enabled underflow did not raise interrupt");

  chk_status_sets: assert property (
    (!soft_reset && event_in != 16'h0000) |=> ((irq_status & $past(event_in)) == $past(event_in)))
    else $error("event did not set its status bit");

  chk_lanes_no_read: assert property (
    (host_req.access && !host_req.write && host_req.be_n == 4'hF) |=> (host_rdata == 32'h0000_0000))
    else $error("read made with all lanes negated");

  chk_upper_zero: assert property (
    host_ack |-> (host_rdata[31:16] == 16'h0000))
    else $error("unused upper bits read nonzero");

  chk_enable_readback: assert property (
    (take && !host_req.write && host_req.addr == mrie_pkg::OFS_IRQ_ENABLE)
      |=> (host_rdata[15:0] == $past(irq_enable)))
    else $error("enable register read back wrong");

  chk_link_pass: assert property (
    !soft_reset |=> (tx_link_data_out == $past(tx_link_data_in)))
    else $error("link data not passed outside software reset");

  chk_soft_write: assert property (
    wr_soft |=> (soft_reset == $past(host_req.wdata[mrie_pkg::SOFT_RESET_BIT])))
    else $error("software reset bit not written");

  chk_standby_off: assert property (
    !soft_reset |-> (!low_power_standby && core_reset_n))
    else $error("standby or core reset without software reset");

  chk_ack_idle: assert property (
    !host_req.access |=> !host_ack)
    else $error("answer without request");

  chk_ack_one: assert property (
    host_req.access |=> host_ack)
    else $error("request not answered");

  cov_soft_release: cover property (soft_reset ##1 !soft_reset);
  cov_irq_raise: cover property (host_interrupt_out_n ##1 !host_interrupt_out_n);
  cov_read_clear_irq: cover property (!host_interrupt_out_n && rd_status ##2 host_interrupt_out_n);
  cov_lanes_negated: cover property (host_req.access && host_req.be_n == 4'hF);

endmodule

//--- rtl/mrie_pkg.sv
// package: offsets, field layout, reset values and carrier types of the master control block
package mrie_pkg;

  localparam int ADDR_W = 11;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 16;
  localparam int LINK_W = 32;

  localparam logic [ADDR_W-1:0] OFS_SOFT_RESET = 11'h000;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 11'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 11'h008;

  localparam int SOFT_RESET_BIT = 15;
  localparam logic SOFT_RESET_RST = 1'h0;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic [3:0] ALL_LANES_NEGATED = 4'hF;
  localparam logic [LINK_W-1:0] LINK_FORCED = 32'hFFFF_FFFF;

  // one bit per event source, bit 15 first
  typedef struct packed {
    logic tx_underflow;
    logic tx_complete;
    logic tx_free_full;
    logic tx_ready_read;
    logic tx_free_write;
    logic rx_ready_full;
    logic rx_free_empty;
    logic rx_ready_write;
    logic rx_large_free_read;
    logic rx_small_free_read;
    logic rx_overrun;
    logic rx_format_error;
    logic rx_abort;
    logic rx_check_error;
    logic parity_error;
    logic sys_error;
  } mrie_irq_bits_t;

  // one host target cycle into the memory window
  typedef struct packed {
    logic access;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [3:0] be_n;
    logic [DATA_W-1:0] wdata;
  } mrie_host_req_t;

endpackage

//--- rtl/mrie_sticky_flags.sv
// sticky event flags with a set that wins over a read clear
`timescale 1ns/1ps
module mrie_sticky_flags #(
  parameter int WIDTH = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic hold_clear, // soft reset: flags held at default
  input wire logic read_clear, // one-cycle clear from a status read
  input wire logic [WIDTH-1:0] set_in, // one-cycle event pulses
  output logic [WIDTH-1:0] flags // sticky flags
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else if (hold_clear) begin
      flags <= '0;
    end else if (read_clear) begin
      // an event in the clear cycle survives the clear
      flags <= set_in;
    end else begin
      flags <= flags | set_in;
    end
  end

endmodule

//--- tb/mrie_host_model.sv
// host bus master model issuing one-cycle target requests to the master control block
`timescale 1ns/1ps
module mrie_host_model (
  input wire logic clk, // system clock
  output mrie_pkg::mrie_host_req_t host_req, // request toward the device
  input wire logic host_ack, // one-cycle answer
  input wire logic [31:0] host_rdata // read data, valid with the answer
);
  initial host_req = '0;

  // lanes follow be_n as given; ok stays low when no answer comes within the bound
  task automatic xfer(input logic wr, input logic [10:0] addr, input logic [3:0] be_n, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic ok);
    int n;
    ok = 1'b0;
    rdata = '0;
    @(negedge clk);
    host_req <= '{access: 1'b1, write: wr, addr: addr, be_n: be_n, wdata: wdata};
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge clk);
      if (host_ack === 1'b1) begin
        ok = 1'b1;
        rdata = host_rdata;
      end
    end
    // released lines show the inverse so stale values never pass for live ones
    host_req <= '{access: 1'b0, write: ~wr, addr: ~addr, be_n: ~be_n, wdata: ~wdata};
  endtask
endmodule

//--- tb/test_master_reset_and_irq_enable.sv
// self-checking bench for the master control block: registers, soft reset, interrupt gating
`timescale 1ns/1ps
module test_master_reset_and_irq_enable;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mrie_pkg::mrie_host_req_t host_req;
  logic host_ack;
  logic [31:0] host_rdata;
  mrie_pkg::mrie_irq_bits_t event_in = '0;
  logic [31:0] tx_link_data_in = 32'hA5C3_3C5A;
  logic [31:0] tx_link_data_out;
  logic irq_n, core_reset_n, config_reset_n, low_power_standby, pci_pin_drive_en;
  int mismatches = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic ok;

  always #12.5 clk = ~clk;

  mrie_master_ctrl uut (
    .clk(clk), .rst_n(rst_n), .host_req(host_req), .host_ack(host_ack), .host_rdata(host_rdata),
    .event_in(event_in), .tx_link_data_in(tx_link_data_in), .tx_link_data_out(tx_link_data_out),
    .host_interrupt_out_n(irq_n), .core_reset_n(core_reset_n), .config_reset_n(config_reset_n),
    .low_power_standby(low_power_standby), .pci_pin_drive_en(pci_pin_drive_en)
  );

  mrie_host_model host (.clk(clk), .host_req(host_req), .host_ack(host_ack), .host_rdata(host_rdata));

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [10:0] a, input logic [3:0] ben, input logic [31:0] d);
    host.xfer(wr, a, ben, d, rd, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, 32'(ok), 32'h1);
      report_and_stop();
    end
  endtask

  task automatic rd_reg(input logic [10:0] a, input logic [3:0] ben, input logic [31:0] exp);
    access(1'b0, a, ben, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic pulse(input logic [15:0] bits);
    @(negedge clk);
    event_in <= bits;
    @(negedge clk);
    event_in <= '0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rst_n <= 1'b1;
    wait_cyc(2);
    check(32'(pci_pin_drive_en), 32'h1);
    check(tx_link_data_out, tx_link_data_in);
    check(32'(irq_n), 32'h1);
    rd_reg(mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'h0000_0000);
    rd_reg(mrie_pkg::OFS_IRQ_ENABLE, 4'h0, 32'h0000_0000);
    rd_reg(mrie_pkg::OFS_IRQ_STATUS, 4'h0, 32'h0000_0000);
    rd_reg(11'h00C, 4'h0, 32'h0000_0000);
    access(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'hE, 32'hFFFF_FFFF);
    rd_reg(mrie_pkg::OFS_IRQ_ENABLE, 4'h7, 32'h0000_FFFF);
    access(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'hF, 32'h0000_0000);
    rd_reg(mrie_pkg::OFS_IRQ_ENABLE, 4'h0, 32'h0000_FFFF);
    access(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'h0, 32'h0000_0000);
    // each source: masked but pollable, then gated through, then cleared by a read
    for (int i = 0; i < 16; i++) begin
      pulse(16'h0001 << i);
      wait_cyc(2);
      check(32'(irq_n), 32'h1);
      access(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'hB, 32'h0000_0001 << i);
      wait_cyc(2);
      check(32'(irq_n), 32'h0);
      rd_reg(mrie_pkg::OFS_IRQ_STATUS, 4'hF, 32'h0000_0000);
      wait_cyc(2);
      check(32'(irq_n), 32'h0);
      rd_reg(mrie_pkg::OFS_IRQ_STATUS, 4'h0, 32'h0000_0001 << i);
      wait_cyc(2);
      check(32'(irq_n), 32'h1);
      access(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'h0, 32'h0000_0000);
    end
    // soft reset with an interrupt pending and the mask loaded
    access(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'h0, 32'h0000_FFFF);
    pulse(16'h0009);
    access(1'b1, mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'hFFFF_FFFF);
    wait_cyc(2);
    check(32'(core_reset_n), 32'h0);
    check(32'(low_power_standby), 32'h1);
    check(32'(pci_pin_drive_en), 32'h1);
    check(tx_link_data_out, 32'hFFFF_FFFF);
    check(32'(config_reset_n), 32'h1);
    check(32'(irq_n), 32'h1);
    rd_reg(mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'h0000_8000);
    rd_reg(mrie_pkg::OFS_IRQ_ENABLE, 4'h0, 32'h0000_0000);
    access(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'h0, 32'h0000_FFFF);
    pulse(16'hFFFF);
    rd_reg(mrie_pkg::OFS_IRQ_ENABLE, 4'h0, 32'h0000_0000);
    rd_reg(mrie_pkg::OFS_IRQ_STATUS, 4'h0, 32'h0000_0000);
    wait_cyc(50);
    rd_reg(mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'h0000_8000);
    access(1'b1, mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'h0000_0000);
    wait_cyc(2);
    check(32'(core_reset_n), 32'h1);
    check(32'(low_power_standby), 32'h0);
    check(tx_link_data_out, tx_link_data_in);
    // hardware reset clears a held soft reset
    access(1'b1, mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'h0000_8000);
    @(negedge clk);
    rst_n <= 1'b0;
    wait_cyc(2);
    check(32'(pci_pin_drive_en), 32'h0);
    check(32'(config_reset_n), 32'h0);
    rst_n <= 1'b1;
    wait_cyc(2);
    rd_reg(mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'h0000_0000);
    check(32'(low_power_standby), 32'h0);
    report_and_stop();
  end
endmodule
